// >>> verilog/pcc_pkg.sv
// Shared constants for the position signal calibration chain
`default_nettype none
package pcc_pkg;
    // Register indexes on the register port
    localparam logic [4:0] A_PROG_ERR = 5'h00;
    localparam logic [4:0] A_FAC_A = 5'h01;
    localparam logic [4:0] A_FAC_B = 5'h02;
    localparam logic [4:0] A_USR_A = 5'h03;
    localparam logic [4:0] A_USR_B = 5'h04;
    localparam logic [4:0] A_LP = 5'h05;
    localparam logic [4:0] A_PHASE = 5'h06;
    localparam logic [4:0] A_GAIN1 = 5'h07;
    localparam logic [4:0] A_GAIN2 = 5'h08;
    localparam logic [4:0] A_COEF0 = 5'h09;
    localparam logic [4:0] A_COEF1 = 5'h0A;
    localparam logic [4:0] A_COEF2 = 5'h0B;
    localparam logic [4:0] A_WGT1 = 5'h0C;
    localparam logic [4:0] A_WGT2 = 5'h0D;
    localparam logic [4:0] A_ZERO = 5'h0E;
    localparam logic [4:0] A_FIELD_TOO_WEAK_FLAG = 5'h0F;
    localparam logic [4:0] A_FIELD_TOO_STRONG_FLAG = 5'h10;
    localparam logic [4:0] A_PREOFF = 5'h11;
    localparam logic [4:0] A_OGAIN = 5'h12;
    localparam logic [4:0] A_OOFF = 5'h13;
    localparam logic [4:0] A_FLOOR = 5'h14;
    localparam logic [4:0] A_CEIL = 5'h15;
    localparam logic [4:0] A_MODSEL = 5'h16;
    localparam logic [4:0] A_SETUP1 = 5'h17;
    localparam logic [4:0] A_DIAG = 5'h18;
    localparam int NREG = 25;
    // Field positions
    localparam int B_HV_LOW = 10;
    localparam int B_SUP_LOW = 9;
    localparam int B_INTERP = 15;
    localparam int B_LOCK = 0;
    localparam int B_TOO_STRONG = 1;
    localparam int B_TOO_WEAK = 0;
    localparam logic [15:0] PROG_ERR_MASK = 16'h0600;
    // Modulo modes
    localparam logic [1:0] MOD_FULL = 2'h0;
    localparam logic [1:0] MOD_90 = 2'h1;
    localparam logic [1:0] MOD_120 = 2'h2;
    // Reset values and scalings
    localparam logic [15:0] UNITY_CH_GAIN = 16'h4000;
    localparam logic [15:0] UNITY_OUT_GAIN = 16'h0200;
    localparam int OUT_GAIN_SHIFT = 9;
    localparam int CH_GAIN_SHIFT = 14;
    localparam int Q15_SHIFT = 15;
    localparam logic [15:0] LP_BYPASS = 16'hFFFF;
    localparam logic [15:0] FULL_SCALE = 16'h7FFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // Timing
    localparam int CLK_HZ = 20000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int INTERP_STEPS = 32;
    localparam int INTERP_SHIFT = 5;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int SUB_CYC = SAMPLE_CYC / INTERP_STEPS;
    localparam int FIFO_DEPTH = 8;
endpackage
`default_nettype wire

// >>> verilog/pcc_chain.sv
// Calibration chain top with its output FIFO
// How it works
// - Sticky bit 10 marks insufficient programming high voltage; 15:11 read zero.
// - Sticky bit 9 marks supply dropout during program or erase; bit 0 zero.
// - Lock bit set: every register stays readable, writes are refused.
// - Two 16-bit factory trace words are read only.
// - Two 16-bit user trace words are writable and retained.
// - First-order low-pass with 16-bit coefficient code, all ones bypasses.
// - Signed sine-scaled phase word corrects channel two; zero means none.
// - Signed channel gains, code 16384 is unity.
// - Channel offset is second-order temperature polynomial of three coefficients.
// - Per-channel weights select and scale the polynomial offset.
// - Coefficient and weight words are signed 16 bits.
// - Signed zero-position word is subtracted from the computed angle.
// - Magnitude outside limit words forces output to ceiling clamp.
// - Modulo select repeats output over 90 or 120 degree segments.
// - Signed pre-offset word is added to the shifted angle.
// - Signed output gain, code 512 is unity over full turn.
// - Output offset word adds twice its value, 32768 is minus 200 percent.
// - Output limited between floor and ceiling clamp words.
// - Interpolator emits 32 linear steps per sample when enabled.
// - Setup register bit 15 switches the interpolator.
// - Diagnosis bit 1 on too strong field, bit 0 on too weak.
`default_nettype none

module pcc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    // Honest full and empty from the fill count
    assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_r != '0;
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // Storage needs no reset; contents are gated by the count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
    property p_no_overflow;
        @(posedge clk_i) disable iff (rst_i) cnt_r <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count beyond depth");
endmodule

module pcc_chain
    import pcc_pkg::*;
#(
    parameter int SAMPLE_CYCLES = pcc_pkg::SAMPLE_CYC,
    parameter int SUB_CYCLES = pcc_pkg::SUB_CYC,
    parameter logic [15:0] FACTORY_A = 16'h1234, // Arbitrary value
    parameter logic [15:0] FACTORY_B = 16'h5678  // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    // Memory programming events
    input wire logic prog_hv_low_i,
    input wire logic prog_supply_low_i,
    input wire logic prog_busy_i,
    // Raw channels and temperature
    input wire logic signed [15:0] ch1_i,
    input wire logic signed [15:0] ch2_i,
    input wire logic [15:0] temp_i,
    // Angle engine link
    output logic signed [15:0] corr_ch1_o,
    output logic signed [15:0] corr_ch2_o,
    output logic corr_valid_o,
    input wire logic [15:0] angle_i,
    input wire logic signed [15:0] magnitude_i,
    // Converter stream
    output logic [15:0] dac_data_o,
    output logic dac_valid_o,
    input wire logic dac_ready_i,
    output logic [15:0] diag_o
);
    if (SUB_CYCLES < 1 || SAMPLE_CYCLES < SUB_CYCLES * INTERP_STEPS)
        $error("sample timing not servable");

    logic [15:0] regs_r [NREG];
    logic [15:0] regs_nxt [NREG];
    logic [15:0] rdata_r, rdata_nxt;
    logic ack_r;
    logic locked;
    assign locked = regs_r[A_SETUP1][B_LOCK];

    // Register writes, lock gating and sticky flags
    always_comb begin
        regs_nxt = regs_r;
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            rdata_nxt = regs_r[reg_addr_i < 5'(NREG) ? reg_addr_i : A_DIAG];
            if (reg_addr_i >= 5'(NREG)) rdata_nxt = ZERO16;
            if (reg_addr_i == A_FAC_A) rdata_nxt = FACTORY_A;
            if (reg_addr_i == A_FAC_B) rdata_nxt = FACTORY_B;
            // Reading the error flags clears them
            if (reg_addr_i == A_PROG_ERR) regs_nxt[A_PROG_ERR] = ZERO16;
        end
        // Read-only words ignore writes; lock refuses the rest
        if (reg_wr_i && !locked && reg_addr_i > A_FAC_B && reg_addr_i < A_DIAG) begin
            regs_nxt[reg_addr_i] = reg_wdata_i;
        end
        // Set wins over the clear-on-read
        if (prog_hv_low_i) regs_nxt[A_PROG_ERR][B_HV_LOW] = 1'b1;
        if (prog_supply_low_i && prog_busy_i) regs_nxt[A_PROG_ERR][B_SUP_LOW] = 1'b1;
        regs_nxt[A_PROG_ERR] = regs_nxt[A_PROG_ERR] & PROG_ERR_MASK;
        regs_nxt[A_FAC_A] = ZERO16;
        regs_nxt[A_FAC_B] = ZERO16;
        regs_nxt[A_DIAG] = diag_o;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NREG; i++) regs_r[i] <= ZERO16;
            regs_r[A_LP] <= LP_BYPASS;
            regs_r[A_GAIN1] <= UNITY_CH_GAIN;
            regs_r[A_GAIN2] <= UNITY_CH_GAIN;
            regs_r[A_OGAIN] <= UNITY_OUT_GAIN;
            regs_r[A_CEIL] <= FULL_SCALE;
            rdata_r <= ZERO16;
            ack_r <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= reg_rd_i || reg_wr_i;
        end
    end
    assign reg_rdata_o = rdata_r;
    assign reg_ack_o = ack_r;

    // Sample and substep timers
    logic [15:0] scnt_r, scnt_nxt, ucnt_r, ucnt_nxt;
    logic tick, subtick;
    assign tick = scnt_r == 16'(SAMPLE_CYCLES - 1);
    assign subtick = ucnt_r == 16'(SUB_CYCLES - 1);
    always_comb begin
        scnt_nxt = tick ? ZERO16 : scnt_r + 16'h0001;
        ucnt_nxt = (subtick || tick) ? ZERO16 : ucnt_r + 16'h0001;
    end

    // Front end: filter, phase, gain, offset
    logic signed [15:0] lp1_r, lp1_nxt, lp2_r, lp2_nxt, c1_r, c1_nxt, c2_r, c2_nxt;
    logic cv_r, cv_nxt;
    logic signed [31:0] d1, d2, p2, g1, g2, tq, poly, o1, o2;
    always_comb begin
        // Coefficient times error; all ones is a true bypass
        d1 = (32'(ch1_i) - 32'(lp1_r)) * $signed({16'h0000, regs_r[A_LP]});
        d2 = (32'(ch2_i) - 32'(lp2_r)) * $signed({16'h0000, regs_r[A_LP]});
        lp1_nxt = tick ? 16'(32'(lp1_r) + (d1 >>> 16)) : lp1_r;
        lp2_nxt = tick ? 16'(32'(lp2_r) + (d2 >>> 16)) : lp2_r;
        if (tick && regs_r[A_LP] == LP_BYPASS) lp1_nxt = ch1_i;
        if (tick && regs_r[A_LP] == LP_BYPASS) lp2_nxt = ch2_i;
        // Sine-scaled crosstalk term, zero code adds nothing
        p2 = 32'(lp2_r) + ((32'(lp1_r) * 32'($signed(regs_r[A_PHASE]))) >>> Q15_SHIFT);
        g1 = (32'(lp1_r) * 32'($signed(regs_r[A_GAIN1]))) >>> CH_GAIN_SHIFT;
        g2 = (p2 * 32'($signed(regs_r[A_GAIN2]))) >>> CH_GAIN_SHIFT;
        // Quadratic temperature offset
        tq = (32'($signed({1'b0, temp_i[14:0]})) * 32'($signed({1'b0, temp_i[14:0]})))
            >>> Q15_SHIFT;
        poly = 32'($signed(regs_r[A_COEF0]))
            + ((32'($signed(regs_r[A_COEF1])) * 32'($signed({1'b0, temp_i[14:0]})))
            >>> Q15_SHIFT)
            + ((32'($signed(regs_r[A_COEF2])) * tq) >>> Q15_SHIFT);
        // Weights switch and scale the offset per channel
        o1 = g1 + ((poly * 32'($signed(regs_r[A_WGT1]))) >>> Q15_SHIFT);
        o2 = g2 + ((poly * 32'($signed(regs_r[A_WGT2]))) >>> Q15_SHIFT);
        c1_nxt = tick ? 16'(o1) : c1_r;
        c2_nxt = tick ? 16'(o2) : c2_r;
        cv_nxt = tick;
    end
    assign corr_ch1_o = c1_r;
    assign corr_ch2_o = c2_r;
    assign corr_valid_o = cv_r;

    // Back end runs in the same cycle the angle engine answers
    logic [15:0] out_r, out_nxt, diag_r, diag_nxt;
    logic ov_r, ov_nxt;
    logic [15:0] rel, seg;
    logic signed [31:0] sc;
    logic hi, lo;
    always_comb begin
        rel = angle_i - regs_r[A_ZERO];
        case (regs_r[A_MODSEL][1:0])
            MOD_90: seg = {1'b0, 15'(rel[14:0] * 15'h0004)};
            MOD_120: seg = {1'b0, 15'(rel[14:0] * 15'h0003)};
            default: seg = {1'b0, rel[14:0]};
        endcase
        seg = seg + regs_r[A_PREOFF];
        // Gain then doubled offset
        sc = ((32'($signed({1'b0, seg[14:0]})) * 32'($signed(regs_r[A_OGAIN])))
            >>> OUT_GAIN_SHIFT) + (32'($signed(regs_r[A_OOFF])) <<< 1);
        hi = magnitude_i > $signed(regs_r[A_FIELD_TOO_STRONG_FLAG]);
        lo = magnitude_i < $signed(regs_r[A_FIELD_TOO_WEAK_FLAG]);
        out_nxt = out_r;
        diag_nxt = diag_r;
        if (cv_r) begin
            // Clamp into the band
            if (sc > 32'($signed({1'b0, regs_r[A_CEIL][14:0]}))) out_nxt = regs_r[A_CEIL];
            else if (sc < 32'($signed({1'b0, regs_r[A_FLOOR][14:0]})))
                out_nxt = regs_r[A_FLOOR];
            else out_nxt = 16'(sc);
            if (hi || lo) out_nxt = regs_r[A_CEIL];
            diag_nxt = ZERO16;
            diag_nxt[B_TOO_STRONG] = hi;
            diag_nxt[B_TOO_WEAK] = lo;
        end
        ov_nxt = cv_r;
    end
    assign diag_o = diag_r;

    // Interpolator stalls when the FIFO is full
    logic [15:0] base_r, base_nxt, tgt_r, tgt_nxt, pd_r, pd_nxt;
    logic [5:0] k_r, k_nxt;
    logic pend_r, pend_nxt, f_ready, interp_on;
    logic signed [31:0] step;
    assign interp_on = regs_r[A_SETUP1][B_INTERP];
    always_comb begin
        base_nxt = base_r;
        tgt_nxt = tgt_r;
        k_nxt = k_r;
        pd_nxt = pd_r;
        pend_nxt = pend_r && !f_ready;
        step = 32'($signed({1'b0, base_r})) + (((32'($signed({1'b0, tgt_r}))
            - 32'($signed({1'b0, base_r}))) * $signed(32'(k_r))) >>> INTERP_SHIFT);
        if (ov_r) begin
            base_nxt = tgt_r;
            tgt_nxt = out_r;
            k_nxt = interp_on ? 6'h01 : 6'h00;
            if (!interp_on) begin
                pd_nxt = out_r;
                pend_nxt = 1'b1;
            end
        end else if (k_r != 6'h00 && !pend_nxt && subtick) begin
            pd_nxt = 16'(step);
            pend_nxt = 1'b1;
            k_nxt = (k_r == 6'(INTERP_STEPS)) ? 6'h00 : k_r + 6'h01;
        end
    end

    logic [15:0] fo_data;
    logic fo_valid, dv_r, dv_nxt;
    logic [15:0] dd_r, dd_nxt;
    pcc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pend_r),
        .in_ready_o(f_ready),
        .in_data_i(pd_r),
        .out_valid_o(fo_valid),
        .out_ready_i(!dv_r || dac_ready_i),
        .out_data_o(fo_data)
    );
    // Output stage keeps the stream ports on flops
    always_comb begin
        dv_nxt = dv_r;
        dd_nxt = dd_r;
        if (!dv_r || dac_ready_i) begin
            dv_nxt = fo_valid;
            dd_nxt = fo_valid ? fo_data : dd_r;
        end
    end
    assign dac_valid_o = dv_r;
    assign dac_data_o = dd_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scnt_r <= ZERO16;
            ucnt_r <= ZERO16;
            lp1_r <= '0;
            lp2_r <= '0;
            c1_r <= '0;
            c2_r <= '0;
            cv_r <= 1'b0;
            out_r <= ZERO16;
            diag_r <= ZERO16;
            ov_r <= 1'b0;
            base_r <= ZERO16;
            tgt_r <= ZERO16;
            pd_r <= ZERO16;
            k_r <= 6'h00;
            pend_r <= 1'b0;
            dv_r <= 1'b0;
            dd_r <= ZERO16;
        end else begin
            scnt_r <= scnt_nxt;
            ucnt_r <= ucnt_nxt;
            lp1_r <= lp1_nxt;
            lp2_r <= lp2_nxt;
            c1_r <= c1_nxt;
            c2_r <= c2_nxt;
            cv_r <= cv_nxt;
            out_r <= out_nxt;
            diag_r <= diag_nxt;
            ov_r <= ov_nxt;
            base_r <= base_nxt;
            tgt_r <= tgt_nxt;
            pd_r <= pd_nxt;
            k_r <= k_nxt;
            pend_r <= pend_nxt;
            dv_r <= dv_nxt;
            dd_r <= dd_nxt;
        end
    end

    // Checks on the logic above
    property p_hv_flag;
        @(posedge clk_i) disable iff (rst_i) prog_hv_low_i |=> regs_r[A_PROG_ERR][B_HV_LOW];
    endproperty
    a_hv_flag: assert property (p_hv_flag) else $error("hv flag not set");
    property p_sup_flag;
        @(posedge clk_i) disable iff (rst_i)
            prog_supply_low_i && prog_busy_i |=> regs_r[A_PROG_ERR][B_SUP_LOW];
    endproperty
    a_sup_flag: assert property (p_sup_flag) else $error("supply flag not set");
    property p_reserved;
        @(posedge clk_i) disable iff (rst_i) (regs_r[A_PROG_ERR] & ~PROG_ERR_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_lock;
        @(posedge clk_i) disable iff (rst_i)
            reg_wr_i && locked && reg_addr_i == A_USR_A |=> $stable(regs_r[A_USR_A]);
    endproperty
    a_lock: assert property (p_lock) else $error("write passed lock");
    property p_factory;
        @(posedge clk_i) disable iff (rst_i)
            reg_rd_i && reg_addr_i == A_FAC_A |=> reg_ack_o && reg_rdata_o == FACTORY_A;
    endproperty
    a_factory: assert property (p_factory) else $error("factory word wrong");
    property p_mag_clamp;
        @(posedge clk_i) disable iff (rst_i)
            cv_r && (hi || lo) |=> out_r == regs_r[A_CEIL] && diag_r[B_TOO_STRONG] == $past(hi);
    endproperty
    a_mag_clamp: assert property (p_mag_clamp) else $error("range check missed");
    property p_band;
        @(posedge clk_i) disable iff (rst_i)
            ov_r && regs_r[A_FLOOR] <= regs_r[A_CEIL] && !$past(hi || lo)
            |-> out_r <= regs_r[A_CEIL] && out_r >= regs_r[A_FLOOR];
    endproperty
    a_band: assert property (p_band) else $error("output outside band");
    property p_direct;
        @(posedge clk_i) disable iff (rst_i) ov_r && !interp_on |=> pend_r && pd_r == $past(out_r);
    endproperty
    a_direct: assert property (p_direct) else $error("bypass push wrong");
    property p_corr_timing;
        @(posedge clk_i) disable iff (rst_i) tick |=> corr_valid_o ##1 !corr_valid_o;
    endproperty
    a_corr_timing: assert property (p_corr_timing) else $error("sample strobe wrong");
    c_locked_write: cover property (@(posedge clk_i) disable iff (rst_i) reg_wr_i && locked);
    c_interp: cover property (@(posedge clk_i) disable iff (rst_i) interp_on && k_r == 6'h20);
    c_stall: cover property (@(posedge clk_i) disable iff (rst_i) pend_r && !f_ready);
    c_mag: cover property (@(posedge clk_i) disable iff (rst_i) cv_r && hi);
endmodule
`default_nettype wire

// >>> testbench/pcc_far_model.sv
// Far-side model: angle engine and converter sink
`default_nettype none
module pcc_far_model (
    input wire logic clk_i,
    // Angle engine side
    input wire logic signed [15:0] corr_ch1_i,
    input wire logic corr_valid_i,
    input wire logic signed [15:0] mag_set_i,
    output logic [15:0] angle_o,
    output logic signed [15:0] magnitude_o,
    // Converter side
    input wire logic [15:0] dac_data_i,
    input wire logic dac_valid_i,
    input wire logic stall_i,
    output logic dac_ready_o,
    output logic [15:0] last_word_o,
    output int words_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Outside the valid cycle the engine shows garbage, never the last result
    assign angle_o = corr_valid_i ? {1'b0, corr_ch1_i[14:0]} : ~{1'b0, corr_ch1_i[14:0]};
    assign magnitude_o = corr_valid_i ? mag_set_i : ~mag_set_i;
    assign dac_ready_o = !stall_i;
    // Count every word the converter accepts and keep the last one
    int cnt = 0;
    logic [15:0] last = 16'h0000;
    always @(posedge clk_i) begin
        if (dac_valid_i && dac_ready_o) begin
            cnt <= cnt + 1;
            last <= dac_data_i;
        end
    end
    assign words_o = cnt;
    assign last_word_o = last;
endmodule
`default_nettype wire

// >>> testbench/test_pcc_chain.sv
// Self-checking bench for the calibration chain
`default_nettype none
module test_pcc_chain;
    import pcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 320;
    localparam logic [15:0] FAC_A = 16'hA5C3; // Arbitrary value
    localparam logic [15:0] FAC_B = 16'h3C5A; // Arbitrary value
    logic clk_i, rst_i, reg_wr_i, reg_rd_i, prog_hv_low_i, prog_supply_low_i, prog_busy_i;
    logic [4:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, temp_i, angle_i, dac_data_o, diag_o, last_word;
    logic signed [15:0] ch1_i, ch2_i, corr_ch1_o, corr_ch2_o, magnitude_i, mag_set;
    logic reg_ack_o, corr_valid_o, dac_valid_o, dac_ready_i, stall;
    int words, n_fail, checks, n0;

    // Short sample period keeps the run brief
    pcc_chain #(.SAMPLE_CYCLES(SC), .SUB_CYCLES(10), .FACTORY_A(FAC_A), .FACTORY_B(FAC_B))
    pcc_chain_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o), .prog_hv_low_i(prog_hv_low_i),
        .prog_supply_low_i(prog_supply_low_i), .prog_busy_i(prog_busy_i), .ch1_i(ch1_i),
        .ch2_i(ch2_i), .temp_i(temp_i), .corr_ch1_o(corr_ch1_o), .corr_ch2_o(corr_ch2_o),
        .corr_valid_o(corr_valid_o), .angle_i(angle_i), .magnitude_i(magnitude_i),
        .dac_data_o(dac_data_o), .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i),
        .diag_o(diag_o));
    pcc_far_model pcc_far_model_inst (.clk_i(clk_i), .corr_ch1_i(corr_ch1_o),
        .corr_valid_i(corr_valid_o), .mag_set_i(mag_set), .angle_o(angle_i),
        .magnitude_o(magnitude_i), .dac_data_i(dac_data_o), .dac_valid_i(dac_valid_o),
        .stall_i(stall), .dac_ready_o(dac_ready_i), .last_word_o(last_word), .words_o(words));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access; ack is looked at in the cycle it stands
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1 chk({15'h0000, reg_ack_o}, 16'h0001);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(reg_rdata_o, exp);
    endtask

    task automatic samples(input int n);
        repeat (n * SC) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        rdc(A_LP, 16'hFFFF);
        rdc(A_GAIN1, 16'h4000);
        rdc(A_GAIN2, 16'h4000);
        rdc(A_PHASE, 16'h0000);
        rdc(A_OGAIN, 16'h0200);
        rdc(A_OOFF, 16'h0000);
        rdc(A_CEIL, 16'h7FFF);
        rdc(A_FLOOR, 16'h0000);
    endtask

    task automatic t_ids();
        acc(1'b1, A_FAC_A, 16'hFFFF);
        rdc(A_FAC_A, FAC_A);
        rdc(A_FAC_B, FAC_B);
        acc(1'b1, A_USR_A, 16'hBEEF);
        acc(1'b1, A_USR_B, 16'h0123);
        rdc(A_USR_A, 16'hBEEF);
        rdc(A_USR_B, 16'h0123);
        rdc(5'h1F, 16'h0000);
    endtask

    // Programmer reads the error flags after a missing second acknowledge
    task automatic t_prog();
        @(posedge clk_i);
        prog_hv_low_i <= 1'b1;
        @(posedge clk_i);
        prog_hv_low_i <= 1'b0;
        rdc(A_PROG_ERR, 16'h0400);
        rdc(A_PROG_ERR, 16'h0000);
        prog_supply_low_i <= 1'b1;
        @(posedge clk_i);
        prog_supply_low_i <= 1'b0;
        rdc(A_PROG_ERR, 16'h0000);
        prog_busy_i <= 1'b1;
        prog_supply_low_i <= 1'b1;
        @(posedge clk_i);
        prog_supply_low_i <= 1'b0;
        prog_busy_i <= 1'b0;
        rdc(A_PROG_ERR, 16'h0200);
    endtask

    // Unity gains and zero phase pass the channels through
    task automatic t_corr();
        samples(3);
        chk(corr_ch1_o, 16'h1000);
        chk(corr_ch2_o, 16'h0800);
        acc(1'b1, A_GAIN1, 16'h2000);
        samples(3);
        chk(corr_ch1_o, 16'h0800);
        acc(1'b1, A_GAIN1, 16'h4000);
    endtask

    // Field outside the limits: flag and ceiling clamp
    task automatic t_mag();
        acc(1'b1, A_FIELD_TOO_WEAK_FLAG, 16'h0100);
        acc(1'b1, A_FIELD_TOO_STRONG_FLAG, 16'h1000);
        acc(1'b1, A_CEIL, 16'h6000);
        mag_set = 16'h2000;
        samples(3);
        chk(diag_o, 16'h0002);
        chk(last_word, 16'h6000);
        n0 = words;
        samples(1);
        chk(16'(words - n0), 16'h0001);
        mag_set = 16'h0050;
        samples(3);
        chk(diag_o, 16'h0001);
        chk(last_word, 16'h6000);
        mag_set = 16'h0800;
        samples(3);
        chk(diag_o, 16'h0000);
        mag_set = 16'h2000;
    endtask

    // Segmenting and angle shifts with the field in range
    task automatic t_mod();
        mag_set = 16'h0800;
        acc(1'b1, A_MODSEL, {14'h0000, MOD_90});
        samples(3);
        chk(last_word, 16'h4000);
        acc(1'b1, A_MODSEL, {14'h0000, MOD_120});
        samples(3);
        chk(last_word, 16'h3000);
        acc(1'b1, A_MODSEL, 16'h0000);
        acc(1'b1, A_ZERO, 16'h0800);
        acc(1'b1, A_PREOFF, 16'h0400);
        samples(3);
        chk(last_word, 16'h0C00);
        acc(1'b1, A_ZERO, 16'h0000);
        acc(1'b1, A_PREOFF, 16'h0000);
        mag_set = 16'h2000;
    endtask

    // Interpolator on, converter stalls then drains
    task automatic t_interp();
        acc(1'b1, A_SETUP1, 16'h8000);
        stall = 1'b1;
        samples(2);
        chk({15'h0000, dac_valid_o}, 16'h0001);
        stall = 1'b0;
        samples(3);
        n0 = words;
        samples(1);
        chk(16'(words - n0), 16'h0020);
        chk(last_word, 16'h6000);
    endtask

    task automatic t_lock();
        acc(1'b1, A_SETUP1, 16'h8001);
        acc(1'b1, A_USR_A, 16'h0000);
        rdc(A_USR_A, 16'hBEEF);
        acc(1'b1, A_SETUP1, 16'h0000);
        rdc(A_SETUP1, 16'h8001);
        rdc(A_FAC_A, FAC_A);
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog well above the roughly 10000 cycles the scenarios take
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        conclude();
    end

    initial begin
        n_fail = 0;
        checks = 0;
        n0 = 0;
        rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, prog_hv_low_i, prog_supply_low_i, prog_busy_i} = 5'h00;
        reg_addr_i = 5'h00;
        reg_wdata_i = 16'h0000;
        ch1_i = 16'h1000;
        ch2_i = 16'h0800;
        temp_i = 16'h0000;
        mag_set = 16'h0800;
        stall = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ids();
        t_prog();
        t_corr();
        t_mag();
        t_mod();
        t_interp();
        t_lock();
        conclude();
    end
endmodule
`default_nettype wire
